// >>> rtl/nvs_cfg.svh
// timing and field constants for the nonvolatile sram host controller
`ifndef NVS_CFG_SVH
`define NVS_CFG_SVH
`define NVS_CLK_PERIOD_NS 10
`define NVS_T_ACCESS_NS   90
`define NVS_T_CE_ACC_NS   60
`define NVS_T_OE_ACC_NS   15
`define NVS_T_PAGE_ACC_NS 30
`define NVS_T_ACTIVE_NS   60
`define NVS_T_PRECHG_NS   30
`define NVS_T_WCYCLE_NS   90
`define NVS_T_WPULSE_NS   18
`define NVS_T_DSETUP_NS   15
`define NVS_T_BDS_NS      5
`define NVS_T_BDH_NS      5
// cycle counts, least times rounded up
`define NVS_CYC(ns) (((ns) + `NVS_CLK_PERIOD_NS - 1) / `NVS_CLK_PERIOD_NS)
`define NVS_RD_CYC   4'(`NVS_CYC(`NVS_T_ACCESS_NS))
`define NVS_PG_CYC   4'(`NVS_CYC(`NVS_T_PAGE_ACC_NS))
`define NVS_PC_CYC   4'(`NVS_CYC(`NVS_T_PRECHG_NS))
`define NVS_WR_CYC   4'(`NVS_CYC(`NVS_T_WCYCLE_NS))
`define NVS_SET_CYC  4'(`NVS_CYC(`NVS_T_BDS_NS))
`define NVS_HOLD_CYC 4'(`NVS_CYC(`NVS_T_BDH_NS))
// two sync stages plus one spare cycle of capture margin
`define NVS_SYNC_CYC 4'h3
`define NVS_ROW_LSB  2
`define NVS_ROW_MSB  15
`define NVS_IDLE_HI  1'h1
`endif

// >>> rtl/nvs_host.sv
// host controller driving an asynchronous nonvolatile sram port
`timescale 1ns/1ns
`include "nvs_cfg.svh"
module nvs_host (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // user request
    input  wire logic              req_valid,
    input  wire nvs_pkg::nvs_req_t req,
    output logic                   req_ready,
    // user answer
    output logic                   rsp_valid,
    output logic [15:0]            rsp_rdata,
    // memory pins
    output nvs_pkg::nvs_pins_t     pins,
    output logic [15:0]            data_lines_o,
    output logic                   data_lines_oe,
    input  wire logic [15:0]       data_lines_i
);
    ////////////////////////////////////////////////////////////////
    // state
    nvs_pkg::nvs_state_t state_reg, state_next;
    nvs_pkg::nvs_pins_t  pins_reg, pins_next;
    nvs_pkg::nvs_req_t   cur_reg, cur_next;
    logic [3:0]  cnt_reg, cnt_next;
    logic [15:0] dout_reg, dout_next;
    logic        doe_reg, doe_next;
    logic        ready_reg, ready_next;
    logic        rvalid_reg, rvalid_next;
    logic [15:0] rdata_reg, rdata_next;
    logic [15:0] din_s1_reg, din_s2_reg;
    logic [3:0]  wait_cyc;

    // row match keeps chip select low for a page access
    function automatic logic same_row(input logic [15:0] a, input logic [15:0] b);
        return a[`NVS_ROW_MSB:`NVS_ROW_LSB] == b[`NVS_ROW_MSB:`NVS_ROW_LSB];
    endfunction

    ////////////////////////////////////////////////////////////////
    // data line synchroniser, two stages
    // only the second stage feeds the read data register
    always_ff @(posedge ref_clk) begin
        din_s1_reg <= data_lines_i;
        din_s2_reg <= din_s1_reg;
    end

    ////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        state_next  = state_reg;
        pins_next   = pins_reg;
        cur_next    = cur_reg;
        cnt_next    = cnt_reg;
        dout_next   = dout_reg;
        doe_next    = doe_reg;
        ready_next  = 1'h0;
        rvalid_next = 1'h0;
        rdata_next  = rdata_reg;
        // read wait covers the sync stages on top of access time
        // spare cycle so the first stage never samples a moving edge
        wait_cyc    = `NVS_RD_CYC + `NVS_SYNC_CYC;
        unique case (state_reg)
            nvs_pkg::NVS_IDLE: begin
                ready_next = 1'h1;
                if (req_valid && ready_reg) begin
                    ready_next = 1'h0;
                    cur_next   = req;
                    pins_next.addr = req.addr;
                    pins_next.upper_byte_select_n = ~req.byte_en[1];
                    pins_next.lower_byte_select_n = ~req.byte_en[0];
                    dout_next  = req.wdata;
                    doe_next   = req.write;
                    cnt_next   = `NVS_SET_CYC;
                    state_next = nvs_pkg::NVS_SETUP;
                end
            end
            nvs_pkg::NVS_SETUP: begin
                pins_next.chip_sel_n = 1'h0;
                pins_next.out_gate_n = cur_reg.write;
                pins_next.write_n    = ~cur_reg.write;
                cnt_next   = cur_reg.write ? `NVS_WR_CYC : wait_cyc;
                state_next = cur_reg.write ? nvs_pkg::NVS_WRITE : nvs_pkg::NVS_READ;
            end
            nvs_pkg::NVS_READ: begin
                if (cnt_reg > 4'h1) begin
                    cnt_next = cnt_reg - 4'h1;
                end else begin
                    rvalid_next = 1'h1;
                    rdata_next  = din_s2_reg;
                    // page read keeps chip select low
                    if (req_valid && !req.write && same_row(req.addr, cur_reg.addr)) begin
                        ready_next     = 1'h1;
                        cur_next       = req;
                        pins_next.addr = req.addr;
                        pins_next.upper_byte_select_n = ~req.byte_en[1];
                        pins_next.lower_byte_select_n = ~req.byte_en[0];
                        // column held for the page wait
                        // same sync margin as a random read
                        cnt_next   = `NVS_PG_CYC + `NVS_SYNC_CYC;
                    end else begin
                        pins_next.out_gate_n = 1'h1;
                        cnt_next   = `NVS_PC_CYC;
                        state_next = nvs_pkg::NVS_PRECHG;
                    end
                end
            end
            nvs_pkg::NVS_WRITE: begin
                // chip select low one cycle past strobe rise
                // byte select low one cycle past chip select rise
                if (cnt_reg > 4'h1) begin
                    cnt_next = cnt_reg - 4'h1;
                end else begin
                    pins_next.write_n = 1'h1;
                    cnt_next   = `NVS_HOLD_CYC;
                    state_next = nvs_pkg::NVS_HOLD;
                end
            end
            nvs_pkg::NVS_HOLD: begin
                pins_next.chip_sel_n = 1'h1;
                doe_next   = 1'h0;
                cnt_next   = `NVS_PC_CYC;
                state_next = nvs_pkg::NVS_PRECHG;
            end
            nvs_pkg::NVS_PRECHG: begin
                pins_next.chip_sel_n = 1'h1;
                pins_next.upper_byte_select_n = `NVS_IDLE_HI;
                pins_next.lower_byte_select_n = `NVS_IDLE_HI;
                if (cnt_reg > 4'h1) begin
                    cnt_next = cnt_reg - 4'h1;
                end else begin
                    ready_next = 1'h1;
                    state_next = nvs_pkg::NVS_IDLE;
                end
            end
            default: begin
                state_next = nvs_pkg::NVS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg  <= nvs_pkg::NVS_IDLE;
            pins_reg   <= '{chip_sel_n: 1'h1, write_n: 1'h1, out_gate_n: 1'h1,
                            upper_byte_select_n: 1'h1, lower_byte_select_n: 1'h1, addr: 16'h0000};
            cur_reg    <= '0;
            cnt_reg    <= 4'h0;
            dout_reg   <= 16'h0000;
            doe_reg    <= 1'h0;
            ready_reg  <= 1'h0;
            rvalid_reg <= 1'h0;
            rdata_reg  <= 16'h0000;
        end else begin
            state_reg  <= state_next;
            pins_reg   <= pins_next;
            cur_reg    <= cur_next;
            cnt_reg    <= cnt_next;
            dout_reg   <= dout_next;
            doe_reg    <= doe_next;
            ready_reg  <= ready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
        end
    end

    // outputs straight from flops
    assign pins          = pins_reg;
    assign data_lines_o  = dout_reg;
    assign data_lines_oe = doe_reg;
    assign req_ready     = ready_reg;
    assign rsp_valid     = rvalid_reg;
    assign rsp_rdata     = rdata_reg;
endmodule

// >>> rtl/nvs_pkg.sv
// types for the nonvolatile sram host controller
package nvs_pkg;
    typedef struct packed {
        logic        write;
        logic [1:0]  byte_en;
        logic [15:0] addr;
        logic [15:0] wdata;
    } nvs_req_t;
    typedef struct packed {
        logic        chip_sel_n;
        logic        write_n;
        logic        out_gate_n;
        logic        upper_byte_select_n;
        logic        lower_byte_select_n;
        logic [15:0] addr;
    } nvs_pins_t;
    typedef enum logic [2:0] {
        NVS_IDLE, NVS_SETUP, NVS_READ, NVS_WRITE, NVS_HOLD, NVS_PRECHG
    } nvs_state_t;
endpackage

// >>> tb/async_nv_sram_cycle_timing_bench.sv
// self-checking bench for the sram host controller
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module async_nv_sram_cycle_timing_bench;
    logic              ref_clk = 1'h0;
    logic              rst = 1'h1;
    logic              req_valid = 1'h0;
    nvs_pkg::nvs_req_t req = '0;
    logic              req_ready, rsp_valid, data_lines_oe;
    logic [15:0]       rsp_rdata, data_lines_o, dq_out, idle_pat = 16'h0000;
    logic [1:0]        dq_en;
    wire [15:0]        data_lines_i;
    nvs_pkg::nvs_pins_t pins;
    logic [15:0]       rq [$];
    int                n_errors = 0;
    int                checks_done = 0;
    always #5 ref_clk = ~ref_clk;
    // floating pattern and answer queue
    always @(posedge ref_clk) begin
        idle_pat <= idle_pat + 16'h1357;
        if (rsp_valid === 1'h1) rq.push_back(rsp_rdata);
    end
    assign data_lines_i[15:8] = data_lines_oe ? data_lines_o[15:8] : dq_en[1] ? dq_out[15:8] : idle_pat[15:8];
    assign data_lines_i[7:0] = data_lines_oe ? data_lines_o[7:0] : dq_en[0] ? dq_out[7:0] : idle_pat[7:0];
    nvs_host u_dut (.ref_clk, .rst, .req_valid, .req, .req_ready, .rsp_valid, .rsp_rdata, .pins,
        .data_lines_o, .data_lines_oe, .data_lines_i);
    nvs_mem_model u_mem (.p(pins), .dq_in(data_lines_i), .dq_out, .dq_en);
    task automatic issue(input logic wr, input logic [1:0] be, input logic [15:0] a, input logic [15:0] d);
        int n;
        // an edge passes so back-to-back calls never re-raise valid in the drop step
        @(posedge ref_clk);
        #1 req_valid = 1'h1;
        req = '{write: wr, byte_en: be, addr: a, wdata: d};
        n = 0;
        do begin @(posedge ref_clk); n++; end while (req_ready !== 1'h1 && n < 100);
        #1 req_valid = 1'h0;
        if (n >= 100) n_errors++;
    endtask
    task automatic expect_rd(input logic [15:0] e);
        int n;
        logic [15:0] got;
        n = 0;
        while (rq.size() == 0 && n < 100) begin @(posedge ref_clk); n++; end
        #1 got = 'x;
        if (rq.size() != 0) got = rq.pop_front();
        `CHK(got, e)
    endtask
    task automatic t_page_rw();
        issue(1'h1, 2'h3, 16'h0040, 16'h1234);
        issue(1'h1, 2'h3, 16'h0043, 16'hBEEF);
        issue(1'h0, 2'h3, 16'h0043, 16'h0000);
        issue(1'h0, 2'h3, 16'h0040, 16'h0000);
        expect_rd(16'hBEEF);
        expect_rd(16'h1234);
    endtask
    task automatic t_byte_mask();
        issue(1'h1, 2'h2, 16'h0040, 16'hAB00);
        issue(1'h1, 2'h1, 16'h0043, 16'h0055);
        issue(1'h1, 2'h0, 16'h0040, 16'hFFFF);
        issue(1'h1, 2'h3, 16'hF3FC, 16'h5AA5);
        issue(1'h0, 2'h3, 16'h0040, 16'h0000);
        issue(1'h0, 2'h3, 16'h0043, 16'h0000);
        issue(1'h0, 2'h3, 16'hF3FC, 16'h0000);
        expect_rd(16'hAB34);
        expect_rd(16'hBE55);
        expect_rd(16'h5AA5);
    endtask
    task automatic t_reset();
        req_valid = 1'h1;
        req = '{write: 1'h1, byte_en: 2'h3, addr: 16'h0100, wdata: 16'h0F0F};
        repeat (3) @(posedge ref_clk);
        #1 rst = 1'h1;
        req_valid = 1'h0;
        repeat (2) @(posedge ref_clk);
        #1 `CHK({pins.chip_sel_n, pins.write_n, data_lines_oe, req_ready}, 4'hC)
        rst = 1'h0;
        @(posedge ref_clk);
        #1 `CHK(req_ready, 1'h1)
        issue(1'h0, 2'h3, 16'hF3FC, 16'h0000);
        expect_rd(16'h5AA5);
    endtask
    task automatic results();
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        #1 rst = 1'h0;
        t_page_rw();
        t_byte_mask();
        t_reset();
        results();
    end
    // watchdog
    initial begin
        #100000;
        n_errors++;
        results();
    end
endmodule

// >>> tb/nvs_host_props.sv
// pin timing assertions for the sram host controller
`timescale 1ns/1ns
module nvs_host_props (
    // clock and reset
    input wire logic               ref_clk,
    input wire logic               rst,
    // user side
    input wire logic               req_valid,
    input wire nvs_pkg::nvs_req_t  req,
    input wire logic               req_ready,
    input wire logic               rsp_valid,
    input wire logic [15:0]        rsp_rdata,
    // memory side
    input wire nvs_pkg::nvs_pins_t pins,
    input wire logic [15:0]        data_lines_o,
    input wire logic               data_lines_oe,
    input wire logic [15:0]        data_lines_i
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire cs = pins.chip_sel_n;
    wire we = pins.write_n;
    property p_active; $fell(cs) |-> !cs[*6]; endproperty
    a_active: assert property (p_active) else $error("chip select low too short");
    property p_prechg; $rose(cs) |-> cs[*3]; endproperty
    a_prechg: assert property (p_prechg) else $error("precharge too short");
    property p_addr; $fell(cs) |-> $stable(pins.addr)[*6]; endproperty
    a_addr: assert property (p_addr) else $error("address moved in access");
    property p_we_cs; $rose(we) |-> !cs && $past(cs, 6) == 1'h0; endproperty
    a_we_cs: assert property (p_we_cs) else $error("chip select not low before strobe end");
    property p_we_len; $fell(we) |-> !we[*8]; endproperty
    a_we_len: assert property (p_we_len) else $error("strobe pulse too short");
    property p_cs_keep; $fell(we) |-> !cs[*3] ##0 $stable(pins.addr[15:2])[*1]; endproperty
    a_cs_keep: assert property (p_cs_keep) else $error("chip off or row moved after strobe");
    property p_data; $rose(we) |-> data_lines_oe && $past(data_lines_o, 2) == data_lines_o; endproperty
    a_data: assert property (p_data) else $error("write data not set up");
    property p_bsel; $changed(we) |-> $stable({pins.upper_byte_select_n, pins.lower_byte_select_n}); endproperty
    a_bsel: assert property (p_bsel) else $error("byte select moved at strobe");
    property p_sample; rsp_valid |-> $past(cs, 1) == 1'h0 && $past(cs, 5) == 1'h0; endproperty
    a_sample: assert property (p_sample) else $error("read sampled too early");
    c_write: cover property ($fell(we));
    c_read: cover property (rsp_valid);
    c_page: cover property (!cs && $changed(pins.addr[1:0]));
endmodule
bind nvs_host nvs_host_props u_props (.ref_clk, .rst, .req_valid, .req, .req_ready, .rsp_valid,
    .rsp_rdata, .pins, .data_lines_o, .data_lines_oe, .data_lines_i);

// >>> tb/nvs_mem_model.sv
// behavioural model of the nonvolatile sram array
`timescale 1ns/1ns
module nvs_mem_model #(parameter int T_ACC = 60, parameter int T_PG = 30) (
    // pins from host
    input wire nvs_pkg::nvs_pins_t p,
    input wire logic [15:0]        dq_in,
    // read drive
    output logic [15:0]            dq_out,
    output logic [1:0]             dq_en
);
    logic [15:0] mem [0:65535];
    logic [13:0] row_lat;
    logic        we_hi = 1'h1;
    always @(negedge p.chip_sel_n) begin
        dq_out <= ~dq_out;
        dq_out <= #T_ACC mem[p.addr];
    end
    always @(p.addr[1:0]) if (!p.chip_sel_n) begin
        dq_out <= #3 ~dq_out;
        dq_out <= #T_PG mem[p.addr];
    end
    always @(p.write_n) if (!p.write_n) we_hi = 1'h0; else we_hi <= #5 1'h1;
    assign dq_en[1] = !p.chip_sel_n && !p.out_gate_n && we_hi && !p.upper_byte_select_n;
    assign dq_en[0] = !p.chip_sel_n && !p.out_gate_n && we_hi && !p.lower_byte_select_n;
    always @(negedge p.write_n) row_lat = p.addr[15:2];
    always @(posedge p.chip_sel_n or posedge p.write_n) if (p.chip_sel_n != p.write_n) begin
        if (!p.upper_byte_select_n) mem[{row_lat, p.addr[1:0]}][15:8] = dq_in[15:8];
        if (!p.lower_byte_select_n) mem[{row_lat, p.addr[1:0]}][7:0] = dq_in[7:0];
    end
endmodule
